/* frc_pkg.sv */
/*
  frc_pkg: constants shared by the fault report capture block.
  assumes a 32-bit plain register port; word offsets are byte addresses.
*/
package frc_pkg;
  localparam int          FRC_NSTRUCT   = 2;
  localparam int          FRC_NFAULT    = 96;
  localparam int          FRC_IDX_W     = 7;
  localparam int          FRC_AW        = 12;
  localparam int          FRC_DW        = 32;
  localparam int          FRC_NINFO     = 4;
  localparam int          FRC_INFO_AW   = 3;
  // per-structure register offsets, structure base = index * stride
  localparam logic [11:0] FRC_STRIDE    = 12'h100;
  localparam logic [7:0]  FRC_CTL       = 8'h00;
  localparam logic [7:0]  FRC_STATE     = 8'h0c;
  localparam logic [7:0]  FRC_INFO0     = 8'h10;
  localparam logic [7:0]  FRC_PEND0     = 8'h40;
  localparam logic [7:0]  FRC_SEL0      = 8'h50;
  localparam logic [7:0]  FRC_IRQ_CAUSE = 8'hc0;
  localparam logic [7:0]  FRC_IRQ_FORCE = 8'hc4;
  localparam logic [7:0]  FRC_IRQ_GATE  = 8'hc8;
  localparam logic [7:0]  FRC_IRQ_GATED = 8'hcc;
  // field positions
  localparam int          FRC_VALID_BIT = 31;
  localparam int          FRC_DMA_BIT   = 0;
  localparam int          FRC_OUT_BIT   = 1;
  localparam int          FRC_RST_BIT   = 2;
  localparam int          FRC_IRQ_BIT   = 0;
  // fault sources in use (indices 0..5, 16..18, 28..38 minus 37, 41, 48)
  localparam logic [95:0] FRC_IMPL_MASK = 96'h0000_0000_0001_025f_f007_003f;
  localparam int          FRC_IDX_SMALL_MPU  = 0;
  localparam int          FRC_IDX_MAIN_MPU   = 16;
  localparam int          FRC_IDX_MAIN_CODE  = 17;
  localparam int          FRC_IDX_MAIN_FLASH = 18;
  localparam int          FRC_IDX_PMS0       = 28;
  localparam int          FRC_IDX_GRP0       = 32;
  localparam int          FRC_IDX_FLASH_BUS  = 48;
  localparam logic [31:0] FRC_GRP0_LO   = 32'h4000_0000;
  localparam logic [31:0] FRC_GRP0_HI   = 32'h4010_0000;
  localparam logic [31:0] FRC_ZERO      = 32'h0000_0000;
endpackage

/* frc_info_if.sv */
/*
  frc_info_if: write and read ports of the captured-info memory.
  assumes both ends run on mclk.
*/
`timescale 1ns/100ps
interface frc_info_if;
  import frc_pkg::*;
  logic              we;
  logic [FRC_INFO_AW+$clog2(FRC_NSTRUCT)-1:0] waddr;
  logic [31:0]       wdata;
  logic [FRC_INFO_AW+$clog2(FRC_NSTRUCT)-1:0] raddr;
  logic [31:0]       rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

/* frc_info_mem.sv */
/*
  frc_info_mem: words of fault information per structure, registered read.
  assumes one write and one read port on mclk; no reset, hard-reset retention is upstream.
*/
`timescale 1ns/100ps
module frc_info_mem #(
  parameter int DEPTH = 8
) (
  input  wire logic mclk,
  input  wire logic clk_en,
  frc_info_if.mem   port
);
  import frc_pkg::*;
  logic [31:0] store [DEPTH];

  always_ff @(posedge mclk) begin
    if (clk_en) begin
      if (port.we) begin
        store[port.waddr] <= port.wdata;
      end
      port.rdata <= store[port.raddr];
    end
  end
endmodule

/* frc_capture.sv */
/*
  frc_capture: fault report capture, pending bits, per-structure capture and outputs.
  assumes fault lines are synchronous to mclk, software on the plain register port,
  hard_rst_n for status, no reset for info and rst_n for the rest (soft reset keeps status and info).
*/
// The register offsets and the strobed register port were decided locally.
// Behaviour
// - pending word 0 holds uncaptured faults 0 to 31.
// - pending words 1 and 2 hold faults 32..63 and 64..95.
// - three capture-select words per structure; capture only where selected.
// - status register gives valid flag and captured fault index.
// - four info words per structure; only word 0 is written, with word 0 of the captured fault, for the lowest capturing structure only.
// - control register enables trigger, output pin and reset request separately.
// - raw interrupt cause is readable, unmasked.
// - writing the force register sets the interrupt cause.
// - interrupt gate decides whether the cause requests an interrupt.
// - gated cause equals raw cause and gate; it drives the interrupt line.
// - index 16 is the main-core system-bus protection violation.
// - index 18 is the main-core code flash controller error.
// - indices 28..31 are periph master violations: small, main, two descriptor DMAs.
// - indices 32..36, 38 and 41 are peripheral group violations.
// - the lowest group covers 0x40000000 up to 0x40100000.
// - index 48 is the flash controller main bus error.
// - index 0 is the small-core protection violation.
// - capture only while valid clear; set valid and clear pending.
// - lower structure wins a shared fault; the other never sees it.
// - ctl bits 0,1,2 enable trigger, pin, reset; asserted while valid.
`timescale 1ns/100ps
module frc_capture #(
  parameter int NS = frc_pkg::FRC_NSTRUCT
) (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic                   hard_rst_n,
  input  wire logic                   clk_en,
  input  wire logic [95:0]            fault_in,
  input  wire logic [31:0]            fault_info [frc_pkg::FRC_NFAULT][frc_pkg::FRC_NINFO],
  input  wire logic [frc_pkg::FRC_AW-1:0] addr,
  input  wire logic [31:0]            wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [31:0]            rdata,
  output logic      [NS-1:0]          fault_irq,
  output logic      [NS-1:0]          fault_dma_trigger,
  output logic      [NS-1:0]          fault_out,
  output logic                        fault_reset_req
);
  import frc_pkg::*;

  typedef struct packed {
    logic [95:0]          pend;
    logic [NS-1:0][95:0]  sel;
    logic [NS-1:0][2:0]   ctl;
    logic [NS-1:0]        cause;
    logic [NS-1:0]        gate;
    logic [NS-1:0]        irq;
    logic [NS-1:0]        dma;
    logic [NS-1:0]        pin;
    logic                 rst_req;
    logic [31:0]          rdata;
    logic                 rd_info;
  } frc_soft_s;

  typedef struct packed {
    logic [NS-1:0]                valid;
    logic [NS-1:0][FRC_IDX_W-1:0] idx;
  } frc_hard_s;

  frc_soft_s s, next_s;
  frc_hard_s h, next_h;
  frc_info_if info ();

  localparam int SW = $clog2(NS) < 1 ? 1 : $clog2(NS);
  logic [SW-1:0]      a_sel;
  logic [7:0]         a_off;
  logic               a_hit;
  logic [NS-1:0]      cap;
  logic [NS-1:0][FRC_IDX_W-1:0] cap_idx;
  logic [95:0]        taken;
  logic [95:0]        avail [NS+1];

  assign a_sel = SW'(addr[FRC_AW-1:8]);
  assign a_off = addr[7:0];
  assign a_hit = 32'(addr[FRC_AW-1:8]) < NS;

  // priority chain: each structure sees only what lower structures left
  assign avail[0] = s.pend;
  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_cap
      logic [95:0] cand;
      always_comb begin
        cand = avail[g] & s.sel[g];
        cap[g] = ~h.valid[g] && (cand != '0);
        cap_idx[g] = '0;
        for (int i = FRC_NFAULT - 1; i >= 0; i--) begin
          if (cand[i]) begin
            cap_idx[g] = FRC_IDX_W'(i);
          end
        end
      end
      assign avail[g+1] = cap[g] ? (avail[g] & ~(96'h1 << cap_idx[g])) : avail[g];
    end
  endgenerate
  assign taken = s.pend & ~avail[NS];

  // info words: one capture per cycle is written; only the lowest capturing structure
  logic [SW-1:0] wr_s;
  logic [1:0]    wr_cnt;
  always_comb begin
    wr_s = '0;
    for (int k = NS - 1; k >= 0; k--) begin
      if (cap[k]) begin
        wr_s = SW'(k);
      end
    end
  end

  always_comb begin
    next_s = s;
    next_h = h;
    // source lines land at their own index; unassigned lines dropped
    next_s.pend = (s.pend & ~taken) | (fault_in & FRC_IMPL_MASK);
    next_s.rd_info = 1'b0;
    next_s.rdata = FRC_ZERO;
    for (int k = 0; k < NS; k++) begin
      if (cap[k]) begin
        next_h.valid[k] = 1'b1;
        next_h.idx[k] = cap_idx[k];
        next_s.cause[k] = 1'b1;
      end
    end
    if (wr && a_hit) begin
      unique case (a_off)
        FRC_CTL:       next_s.ctl[a_sel] = wdata[2:0];
        FRC_STATE:     begin
          // a capture in the same cycle wins over the software write
          next_h.valid[a_sel] = wdata[FRC_VALID_BIT] | cap[a_sel];
          if (!cap[a_sel]) begin
            next_h.idx[a_sel] = wdata[FRC_IDX_W-1:0];
          end
        end
        FRC_SEL0:      next_s.sel[a_sel][31:0] = wdata & FRC_IMPL_MASK[31:0];
        FRC_SEL0 + 8'h04: next_s.sel[a_sel][63:32] = wdata & FRC_IMPL_MASK[63:32];
        FRC_SEL0 + 8'h08: next_s.sel[a_sel][95:64] = wdata & FRC_IMPL_MASK[95:64];
        FRC_IRQ_CAUSE: next_s.cause[a_sel] = s.cause[a_sel] & ~wdata[FRC_IRQ_BIT] | cap[a_sel];
        FRC_IRQ_FORCE: next_s.cause[a_sel] = s.cause[a_sel] | wdata[FRC_IRQ_BIT];
        FRC_IRQ_GATE:  next_s.gate[a_sel] = wdata[FRC_IRQ_BIT];
        default:       ;
      endcase
    end
    if (rd && a_hit) begin
      unique case (a_off)
        FRC_CTL:       next_s.rdata = {29'h0, s.ctl[a_sel]};
        FRC_STATE:     next_s.rdata = {h.valid[a_sel], 24'h0, h.idx[a_sel]};
        FRC_INFO0, FRC_INFO0 + 8'h04, FRC_INFO0 + 8'h08, FRC_INFO0 + 8'h0c:
                       next_s.rd_info = 1'b1;
        FRC_PEND0:     next_s.rdata = s.pend[31:0];
        FRC_PEND0 + 8'h04: next_s.rdata = s.pend[63:32];
        FRC_PEND0 + 8'h08: next_s.rdata = s.pend[95:64];
        FRC_SEL0:      next_s.rdata = s.sel[a_sel][31:0];
        FRC_SEL0 + 8'h04: next_s.rdata = s.sel[a_sel][63:32];
        FRC_SEL0 + 8'h08: next_s.rdata = s.sel[a_sel][95:64];
        FRC_IRQ_CAUSE, FRC_IRQ_FORCE:
                       next_s.rdata = {31'h0, s.cause[a_sel]};
        FRC_IRQ_GATE:  next_s.rdata = {31'h0, s.gate[a_sel]};
        FRC_IRQ_GATED: next_s.rdata = {31'h0, s.cause[a_sel] & s.gate[a_sel]};
        default:       next_s.rdata = FRC_ZERO;
      endcase
    end
    for (int k = 0; k < NS; k++) begin
      next_s.irq[k] = next_s.cause[k] & next_s.gate[k];
      next_s.dma[k] = next_h.valid[k] & next_s.ctl[k][FRC_DMA_BIT];
      next_s.pin[k] = next_h.valid[k] & next_s.ctl[k][FRC_OUT_BIT];
    end
    next_s.rst_req = 1'b0;
    for (int k = 0; k < NS; k++) begin
      next_s.rst_req = next_s.rst_req | (next_h.valid[k] & next_s.ctl[k][FRC_RST_BIT]);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  always_ff @(posedge mclk or negedge hard_rst_n) begin
    if (!hard_rst_n) begin
      h <= '0;
    end else if (clk_en) begin
      h <= next_h;
    end
  end

  // info writes: only word 0 of the winning capture's source is written
  assign info.we    = |cap;
  assign info.waddr = {wr_s, 3'(wr_cnt)};
  assign info.wdata = fault_info[cap_idx[wr_s]][wr_cnt];
  assign info.raddr = {a_sel, 3'(a_off[3:2])};
  assign wr_cnt     = 2'(a_off[3:2]) & 2'h0;
  assign rdata      = s.rd_info ? info.rdata : s.rdata;
  assign fault_irq         = s.irq;
  assign fault_dma_trigger = s.dma;
  assign fault_out         = s.pin;
  assign fault_reset_req   = s.rst_req;

  frc_info_mem #(.DEPTH(NS * 8)) u_info (
    .mclk   (mclk),
    .clk_en (clk_en),
    .port   (info)
  );

  a_pend_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && cap[0] |=> !s.pend[$past(cap_idx[0])] || $past(fault_in[cap_idx[0]]))
    else $error("captured pending bit not cleared");
  a_valid_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    h.valid[0] && !(wr && a_off == FRC_STATE) |-> !cap[0])
    else $error("capture while valid");
  a_lower_wins: assert property (@(posedge mclk) disable iff (!rst_n)
    cap[0] && cap[1] |-> cap_idx[0] != cap_idx[1])
    else $error("two structures took one fault");
  a_unimpl_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    (s.pend & ~FRC_IMPL_MASK) == '0)
    else $error("unassigned pending bit set");
  a_force_irq: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && wr && a_hit && a_off == FRC_IRQ_FORCE && wdata[0] |=> s.cause[$past(a_sel)])
    else $error("force did not set cause");
  a_gate_line: assert property (@(posedge mclk) disable iff (!rst_n)
    fault_irq == (s.cause & s.gate))
    else $error("irq line differs from gated cause");
  a_dma_follow: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && cap[0] && s.ctl[0][FRC_DMA_BIT] |=> fault_dma_trigger[0])
    else $error("trigger missing after capture");
  a_status_idx: assert property (@(posedge mclk) disable iff (!rst_n)
    clk_en && cap[0] |=> h.valid[0] && h.idx[0] == $past(cap_idx[0]))
    else $error("status index wrong");
  c_capture:  cover property (@(posedge mclk) cap[0]);
  c_shared:   cover property (@(posedge mclk) cap[0] && cap[1]);
  c_irq:      cover property (@(posedge mclk) fault_irq[0]);
  c_reset_rq: cover property (@(posedge mclk) fault_reset_req);
endmodule

/* frc_src_model.sv */
/*
  frc_src_model: fault sources facing the capture block.
  assumes the bench names the lines to fire; info words are a fixed pattern.
*/
`timescale 1ns/100ps
module frc_src_model (
  input  wire logic        mclk,
  input  wire logic [95:0] fire,
  output logic      [95:0] fault_in,
  output logic      [31:0] info [frc_pkg::FRC_NFAULT][frc_pkg::FRC_NINFO]
);
  import frc_pkg::*;
  // fault lines rise one cycle after the bench asks for them
  always_ff @(posedge mclk) begin
    fault_in <= fire;
  end
  // info word = index in bits 15:8, word number below
  always_comb begin
    for (int i = 0; i < FRC_NFAULT; i++) begin
      for (int w = 0; w < FRC_NINFO; w++) begin
        info[i][w] = 32'(i * 256 + w);
      end
    end
  end
endmodule

/* tb.sv */
/*
  tb: self-checking bench for the fault report capture block.
  assumes two structures and the offsets of frc_pkg.
*/
`timescale 1ns/100ps
module tb;
  import frc_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hard_rst_n = 1'b0;
  logic [95:0] fire = '0;
  logic [95:0] fault_in;
  logic [31:0] finfo [FRC_NFAULT][FRC_NINFO];
  logic [11:0] addr = '0;
  logic [31:0] wdata = '0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic [1:0]  irq, dma, fout;
  logic        rreq;
  int          err_total = 0;
  int          n_checks = 0;

  always #25 mclk = ~mclk;

  frc_src_model u_src (.mclk(mclk), .fire(fire), .fault_in(fault_in), .info(finfo));
  frc_capture u_dut (.mclk(mclk), .rst_n(rst_n), .hard_rst_n(hard_rst_n), .clk_en(1'b1),
    .fault_in(fault_in), .fault_info(finfo), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .fault_irq(irq), .fault_dma_trigger(dma), .fault_out(fout),
    .fault_reset_req(rreq));

  task automatic stop_test;
    if (err_total == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic [11:0] ra(input int s, input logic [7:0] off);
    return {s[3:0], off};
  endfunction

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  task automatic rd_reg(input string n, input logic [11:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(n, e, rdata);
  endtask

  task automatic chk_out(input logic [31:0] e);
    repeat (3) @(posedge mclk);
    #1 chk("outputs", e, {24'h0, irq, fout, dma, 1'b0, rreq});
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    rst_n      <= 1'b1;
    hard_rst_n <= 1'b1;
    rd_reg("ctl", ra(0, FRC_CTL), 32'h0);
    rd_reg("state", ra(0, FRC_STATE), 32'h0);
    wr_reg(ra(0, FRC_SEL0), 32'h2000_0000);
    wr_reg(ra(1, FRC_SEL0), 32'h2000_0000);
    wr_reg(ra(0, FRC_CTL), 32'h7);
    @(posedge mclk);
    fire <= '1;
    @(posedge mclk);
    fire <= '0;
    chk_out(32'h0000_0015);
    rd_reg("state0", ra(0, FRC_STATE), 32'h8000_001d);
    rd_reg("state1", ra(1, FRC_STATE), 32'h0);
    rd_reg("pend0", ra(0, FRC_PEND0), FRC_IMPL_MASK[31:0] & 32'hdfff_ffff);
    rd_reg("pend1", ra(1, FRC_PEND0 + 8'h4), FRC_IMPL_MASK[63:32]);
    rd_reg("pend2", ra(0, FRC_PEND0 + 8'h8), FRC_IMPL_MASK[95:64]);
    rd_reg("small_mpu", ra(1, FRC_PEND0), 32'hd007_003f);
    rd_reg("periph_ms", ra(0, FRC_PEND0), 32'hd007_003f);
    rd_reg("grp_pend", ra(0, FRC_PEND0 + 8'h4), 32'h0001_025f);
    rd_reg("flash_bus", ra(1, FRC_PEND0 + 8'h4), 32'h0001_025f);
    rd_reg("rsv_pend", ra(1, FRC_PEND0 + 8'h8), 32'h0);
    rd_reg("info0", ra(0, FRC_INFO0), 32'h0000_1d00);
    for (int b = 0; b < 3; b++) begin
      wr_reg(ra(0, FRC_CTL), 32'(1 << b));
      chk_out(32'(b == 0 ? 4 : b == 1 ? 16 : 1));
    end
    rd_reg("cause", ra(0, FRC_IRQ_CAUSE), 32'h1);
    wr_reg(ra(0, FRC_IRQ_GATE), 32'h1);
    chk_out(32'h41);
    rd_reg("gated", ra(0, FRC_IRQ_GATED), 32'h1);
    wr_reg(ra(0, FRC_IRQ_CAUSE), 32'h1);
    rd_reg("gated", ra(0, FRC_IRQ_GATED), 32'h0);
    wr_reg(ra(0, FRC_IRQ_FORCE), 32'h1);
    rd_reg("cause", ra(0, FRC_IRQ_CAUSE), 32'h1);
    wr_reg(ra(0, FRC_IRQ_GATE), 32'h0);
    chk_out(32'h1);
    wr_reg(ra(0, FRC_SEL0), 32'h0001_0000);
    rd_reg("state0", ra(0, FRC_STATE), 32'h8000_001d);
    wr_reg(ra(0, FRC_STATE), 32'h0);
    rd_reg("state0", ra(0, FRC_STATE), 32'h8000_0010);
    rd_reg("pend0", ra(0, FRC_PEND0), FRC_IMPL_MASK[31:0] & 32'hdffe_ffff);
    wr_reg(ra(1, FRC_SEL0), 32'h0004_0000);
    rd_reg("state1", ra(1, FRC_STATE), 32'h8000_0012);
    rd_reg("info1", ra(1, FRC_INFO0), 32'h0000_1200);
    wr_reg(ra(1, FRC_STATE), 32'h0);
    wr_reg(ra(1, FRC_SEL0), 32'h0002_0000);
    rd_reg("state1", ra(1, FRC_STATE), 32'h8000_0011);
    @(posedge mclk);
    rst_n <= 1'b0;
    @(posedge mclk);
    rst_n <= 1'b1;
    rd_reg("state0", ra(0, FRC_STATE), 32'h8000_0010);
    chk_out(32'h0);
    rd_reg("unmapped", ra(0, 8'h20), 32'h0);
    rd_reg("struct2", ra(2, FRC_STATE), 32'h0);
    stop_test();
  end

  initial begin
    #(3000 * 50);
    err_total++;
    stop_test();
  end
endmodule
